// ### verilog/load_state_pkg.sv
// Constants, encodings and carriers for the load state command block.
// Assumes a host-side parser that turns text commands into decoded words.
package load_state_pkg;

  // Status register layouts
  localparam int          ERR_CH1_LSB   = 0;
  localparam int          ERR_CH1_W     = 4;
  localparam int          ERR_OPER_BIT  = 4;
  localparam int          ERR_CMD_BIT   = 5;
  localparam int          TRIP_OPP_BIT  = 0;
  localparam int          TRIP_OTP_BIT  = 1;
  localparam int          TRIP_OVP_BIT  = 2;
  localparam int          TRIP_OCP_BIT  = 3;
  localparam logic [7:0]  ERR_RST       = 8'h00;
  localparam logic [7:0]  TRIP_RST      = 8'h00;
  localparam logic [7:0]  ERR_USED      = 8'h3f;
  localparam logic [7:0]  TRIP_USED     = 8'h0f;

  // Measurement and limit width
  localparam int          MEAS_W        = 16;
  localparam logic [15:0] LIM_HI_RST    = 16'hffff;
  localparam logic [15:0] LIM_LO_RST    = 16'h0000;

  // Argument encodings
  localparam logic [1:0]  ARG_OFF       = 2'h0;
  localparam logic [1:0]  ARG_ON        = 2'h1;
  localparam logic [1:0]  ARG_AUTO      = 2'h2;
  localparam logic [1:0]  ARG_LOW       = 2'h0;
  localparam logic [1:0]  ARG_HIGH      = 2'h1;

  // Command opcodes as delivered by the parser
  localparam logic [3:0]  OP_LOAD       = 4'h0;
  localparam logic [3:0]  OP_MODE       = 4'h1;
  localparam logic [3:0]  OP_SHORT      = 4'h2;
  localparam logic [3:0]  OP_PRESET     = 4'h3;
  localparam logic [3:0]  OP_SENSE      = 4'h4;
  localparam logic [3:0]  OP_LEVEL      = 4'h5;
  localparam logic [3:0]  OP_DYNAMIC    = 4'h6;
  localparam logic [3:0]  OP_CLR        = 4'h7;
  localparam logic [3:0]  OP_ERROR      = 4'h8;
  localparam logic [3:0]  OP_LIMFAIL    = 4'h9;
  localparam logic [3:0]  OP_TRIP       = 4'ha;

  typedef enum logic [1:0] {
    constant_current_mode,
    constant_resistance_mode,
    constant_voltage_mode,
    constant_power_mode
  } reg_mode_t;

  typedef enum logic [1:0] {
    sense_off,
    sense_on,
    sense_auto
  } sense_t;

  // One decoded command word
  typedef struct packed {
    logic       query;
    logic       malformed;
    logic [3:0] op;
    logic [1:0] arg;
  } cmd_t;

  // Operating state driven to the load's power stage
  typedef struct packed {
    logic      input_on;
    reg_mode_t mode;
    logic      short_on;
    logic      preset_on;
    sense_t    sense;
    logic      level_high;
    logic      dynamic_on;
  } op_state_t;

  // Limit pair as programmed
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } limits_t;

endpackage

// ### verilog/limit_check.sv
// Limit pair storage and the limit-fail comparator.
// Assumes the measurement input is already on the clk domain.
`timescale 1ns/1ps
module limit_check
  import load_state_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              lim_wr,
  input  wire limits_t           lim_new,
  input  wire logic [MEAS_W-1:0] measured,
  output logic                   lim_refused,
  output limits_t                lim_now,
  output logic                   limit_fail_flag
);

  limits_t lim_ff;
  logic    fail_ff;
  logic    refuse_ff;
  logic    pair_bad;
  logic    nxt_fail;

  // An inverted pair would make the flag stick on, so it is dropped
  assign pair_bad = lim_new.lo > lim_new.hi;
  assign nxt_fail = (measured > lim_ff.hi) || (measured < lim_ff.lo);

  // Limit storage, refusal pulse and flag register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lim_ff    <= {LIM_HI_RST, LIM_LO_RST};
      fail_ff   <= 1'b0;
      refuse_ff <= 1'b0;
    end else begin
      if (lim_wr && !pair_bad) begin
        lim_ff <= lim_new;
      end
      refuse_ff <= lim_wr && pair_bad;
      fail_ff   <= nxt_fail;
    end
  end

  assign lim_refused     = refuse_ff;
  assign lim_now         = lim_ff;
  assign limit_fail_flag = fail_ff;

endmodule

// ### verilog/load_state_cmd.sv
// State command interpreter of the programmable load: operating state,
// error and trip status, limit-fail indication and their queries.
// Assumes a parser upstream delivering one decoded command per cmd_valid,
// and asynchronous event pins that are synchronised here.
//
// Notes on behaviour
// - State commands are accepted in any cycle, test running or not.
// - Input on/off command; query answers 0 off, 1 on.
// - Mode command selects current, resistance, voltage, power; query 0..3.
// - Short test query answers 0 while active, 1 while inactive.
// - Preset on/off command; query answers 0 off, 1 on.
// - Sense on, off or auto; query answers 1 only for on.
// - Two setpoints kept, high or low selected; query 0 low, 1 high.
// - Static or dynamic command; query answers 0 dynamic, 1 static.
// - Flag wipe command zeroes error and trip status registers.
// - Error bits: channel one 0-3, operation 4, command 5.
// - Error bits stay set until wiped; readable by query at any time.
// - Trip bits: power 0, temperature 1, voltage 2, current 3.
// - Trip bits latch until wiped; query returns current contents.
// - Limit-fail query answers 1 while indicator lit, else 0.
// - Limit-fail set when measurement is above high or below low limit.
// - A low limit above the high limit is refused.
`timescale 1ns/1ps
module load_state_cmd
  import load_state_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              cmd_valid,
  input  wire cmd_t              cmd,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  input  wire logic [3:0]        ch1_err_pin,
  input  wire logic              oper_err_pin,
  input  wire logic              over_power_trip,
  input  wire logic              over_temp_trip,
  input  wire logic              over_voltage_trip,
  input  wire logic              over_current_trip,
  input  wire logic              lim_wr,
  input  wire limits_t           lim_new,
  input  wire logic [MEAS_W-1:0] measured,
  output op_state_t              op_state,
  output limits_t                lim_now,
  output logic                   limit_fail_flag,
  output logic [7:0]             error_status,
  output logic [7:0]             trip_status
);

  // Event pins arrive unsynchronised: two stages before any use
  logic [8:0] evt_meta_ff;
  logic [8:0] evt_sync_ff;
  logic [8:0] evt_pins;

  op_state_t  st_ff;
  op_state_t  nxt_st;
  logic [7:0] err_ff;
  logic [7:0] trip_ff;
  logic [7:0] nxt_err;
  logic [7:0] nxt_trip;
  logic [7:0] err_set;
  logic [7:0] trip_set;
  logic       rsp_v_ff;
  logic [7:0] rsp_ff;
  logic [7:0] nxt_rsp;
  logic       lim_refused;
  logic [3:0] ch1_evt;
  logic       oper_evt;

  // Single-bit query answers; the inverted encodings are made here
  logic       ans_load;
  logic       ans_short;
  logic       ans_preset;
  logic       ans_sense;
  logic       ans_level;
  logic       ans_static;

  // Command decode
  logic       is_set;
  logic       is_query;
  logic       arg_ok;
  logic       op_known;
  logic       cmd_bad;
  logic       wipe;

  assign evt_pins = {oper_err_pin, ch1_err_pin, over_current_trip,
                     over_voltage_trip, over_temp_trip, over_power_trip};

  // Two-stage synchroniser; only the second stage feeds the status logic
  // A pulse shorter than one clock may be missed: sources must hold it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_meta_ff <= 9'h000;
      evt_sync_ff <= 9'h000;
    end else begin
      evt_meta_ff <= evt_pins;
      evt_sync_ff <= evt_meta_ff;
    end
  end

  // Legal argument check, shared by the set decode below
  // Mode takes any of its four codes; sense refuses the spare code
  function automatic logic arg_legal(input logic [3:0] op,
                                     input logic [1:0] arg);
    case (op)
      OP_MODE:  arg_legal = 1'b1;
      OP_SENSE: arg_legal = (arg != 2'h3);
      default:  arg_legal = (arg == ARG_OFF) || (arg == ARG_ON);
    endcase
  endfunction

  // Accepted in every cycle; no busy state exists to block it
  // Which opcodes exist, and in which form
  assign op_known = cmd.query ? (cmd.op <= OP_TRIP) && (cmd.op != OP_CLR)
                              : (cmd.op <= OP_CLR);
  assign arg_ok   = cmd.query || (cmd.op == OP_CLR) ||
                    arg_legal(cmd.op, cmd.arg);
  assign cmd_bad  = cmd_valid && (cmd.malformed || !op_known || !arg_ok);
  assign is_set   = cmd_valid && !cmd_bad && !cmd.query;
  assign is_query = cmd_valid && !cmd_bad && cmd.query;
  assign wipe     = is_set && (cmd.op == OP_CLR);

  // Next operating state; a rejected command leaves it as it is
  always_comb begin
    nxt_st = st_ff;
    if (is_set) begin
      case (cmd.op)
        OP_LOAD:    nxt_st.input_on   = cmd.arg[0];
        OP_MODE:    nxt_st.mode       = reg_mode_t'(cmd.arg);
        OP_SHORT:   nxt_st.short_on   = cmd.arg[0];
        OP_PRESET:  nxt_st.preset_on  = cmd.arg[0];
        OP_SENSE:   nxt_st.sense      = sense_t'(cmd.arg);
        OP_LEVEL:   nxt_st.level_high = (cmd.arg == ARG_HIGH);
        OP_DYNAMIC: nxt_st.dynamic_on = cmd.arg[0];
        default:    nxt_st = st_ff;
      endcase
    end
  end

  // Channel and operation events; a refused limit pair counts as the
  // latter, since the host asked for something the load cannot do
  assign ch1_evt  = evt_sync_ff[7:4];
  assign oper_evt = evt_sync_ff[8] | lim_refused;

  // Event sources for both status registers
  assign err_set  = {2'b00, cmd_bad, oper_evt, ch1_evt} & ERR_USED;
  assign trip_set = {4'h0, evt_sync_ff[TRIP_OCP_BIT],
                     evt_sync_ff[TRIP_OVP_BIT], evt_sync_ff[TRIP_OTP_BIT],
                     evt_sync_ff[TRIP_OPP_BIT]} & TRIP_USED;

  // A new event in the wipe cycle survives: set beats clear,
  // so a trip that lands together with the wipe is never lost
  assign nxt_err  = (wipe ? ERR_RST : err_ff) | err_set;
  assign nxt_trip = (wipe ? TRIP_RST : trip_ff) | trip_set;

  // Short and static answers read inverted against the stored flags
  assign ans_load   = st_ff.input_on;
  assign ans_short  = !st_ff.short_on;
  assign ans_preset = st_ff.preset_on;
  assign ans_sense  = (st_ff.sense == sense_on);
  assign ans_level  = st_ff.level_high;
  assign ans_static = !st_ff.dynamic_on;

  // Query answer, taken from current register contents
  always_comb begin
    nxt_rsp = 8'h00;
    case (cmd.op)
      OP_LOAD:    nxt_rsp = {7'h00, ans_load};
      OP_MODE:    nxt_rsp = {6'h00, st_ff.mode};
      OP_SHORT:   nxt_rsp = {7'h00, ans_short};
      OP_PRESET:  nxt_rsp = {7'h00, ans_preset};
      OP_SENSE:   nxt_rsp = {7'h00, ans_sense};
      OP_LEVEL:   nxt_rsp = {7'h00, ans_level};
      OP_DYNAMIC: nxt_rsp = {7'h00, ans_static};
      OP_ERROR:   nxt_rsp = err_ff & ERR_USED;
      OP_LIMFAIL: nxt_rsp = {7'h00, limit_fail_flag};
      OP_TRIP:    nxt_rsp = trip_ff & TRIP_USED;
      default:    nxt_rsp = 8'h00;
    endcase
  end

  // State and status registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff   <= '0;
      err_ff  <= ERR_RST;
      trip_ff <= TRIP_RST;
    end else begin
      st_ff   <= nxt_st;
      err_ff  <= nxt_err;
      trip_ff <= nxt_trip;
    end
  end

  // Answer register; holds its data until the next query
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_v_ff <= 1'b0;
      rsp_ff   <= 8'h00;
    end else begin
      rsp_v_ff <= is_query;
      if (is_query) begin
        rsp_ff <= nxt_rsp;
      end
    end
  end

  // Limits and the comparator live in their own module
  limit_check u_limit (
    .clk             (clk),
    .rst_b           (rst_b),
    .lim_wr          (lim_wr),
    .lim_new         (lim_new),
    .measured        (measured),
    .lim_refused     (lim_refused),
    .lim_now         (lim_now),
    .limit_fail_flag (limit_fail_flag)
  );

  // Outputs straight from registers; nothing combinational leaves here
  assign rsp_valid    = rsp_v_ff;
  assign rsp_data     = rsp_ff;
  assign op_state     = st_ff;
  assign error_status = err_ff;
  assign trip_status  = trip_ff;

endmodule

// ### dv/load_state_asserts.sv
// Checker for the load state command block, bound to its top.
// Assumes one clock domain and the package opcodes.
`timescale 1ns/1ps
module load_state_asserts
  import load_state_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cmd_valid,
  input wire cmd_t       cmd,
  input wire logic       rsp_valid,
  input wire logic       lim_wr,
  input wire limits_t    lim_new,
  input wire op_state_t  op_state,
  input wire limits_t    lim_now,
  input wire logic [7:0] error_status,
  input wire logic [7:0] trip_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Well formed set command, and the wipe among them
  wire set_ok = cmd_valid && !cmd.query && !cmd.malformed;
  wire is_clr = set_ok && cmd.op == OP_CLR;

  property p_ans;
    cmd_valid && cmd.query && !cmd.malformed && cmd.op == OP_ERROR
      |=> rsp_valid;
  endproperty
  a_ans: assert property (p_ans) else $error("query not answered");
  property p_quiet;
    cmd_valid && !cmd.query |=> !rsp_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("set answered");
  property p_load;
    set_ok && cmd.op == OP_LOAD && !cmd.arg[1]
      |=> op_state.input_on == $past(cmd.arg[0]);
  endproperty
  a_load: assert property (p_load) else $error("input switch");
  property p_mode;
    set_ok && cmd.op == OP_MODE |=> op_state.mode == $past(cmd.arg);
  endproperty
  a_mode: assert property (p_mode) else $error("mode select");
  property p_bad;
    cmd_valid && cmd.malformed |=> error_status[5] && $stable(op_state);
  endproperty
  a_bad: assert property (p_bad) else $error("bad command");
  property p_unused;
    error_status[7:6] == 2'h0 && trip_status[7:4] == 4'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("spare bits");
  // Sticky bits only fall on a wipe
  property p_keep;
    |error_status && !is_clr
      |=> (error_status & $past(error_status)) == $past(error_status);
  endproperty
  a_keep: assert property (p_keep) else $error("error bit lost");
  property p_trip;
    |trip_status && !is_clr
      |=> (trip_status & $past(trip_status)) == $past(trip_status);
  endproperty
  a_trip: assert property (p_trip) else $error("trip bit lost");
  property p_refuse;
    lim_wr && lim_new.lo > lim_new.hi
      |=> lim_now == $past(lim_now) ##1 error_status[4];
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad pair");
  c_ans: cover property (rsp_valid);
  c_clr: cover property (is_clr);
  c_bad: cover property (cmd_valid && cmd.malformed);
endmodule
bind load_state_cmd load_state_asserts chk_u (.*);

// ### dv/host_model.sv
// Remote host model: issues decoded commands and collects answers.
// Assumes the block takes a command at each rising edge with cmd_valid.
`timescale 1ns/1ps
module host_model
  import load_state_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  output logic            cmd_valid,
  output cmd_t            cmd
);
  initial begin
    cmd_valid = 1'b0;
    cmd = 8'h00;
  end
  // Changes after a falling edge, held over the next rising edge
  task send(input logic q, m, input logic [3:0] op, input logic [1:0] a);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = {q, m, op, a};
  endtask
  // Released word flips so a stale command never looks valid
  task idle;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd = ~cmd;
  endtask
  // Bounded wait; a missing answer comes back unknown
  task ask(input logic [3:0] op, output logic [7:0] d);
    d = 8'hxx;
    send(1'b1, 1'b0, op, 2'h0);
    idle;
    // The answer stands only in the cycle after the take: look first
    repeat (3) begin
      if (rsp_valid === 1'b1)
        d = rsp_data;
      @(negedge clk);
    end
  endtask
endmodule

// ### dv/load_state_cmd_bench.sv
// Self-checking bench of the load state command block.
// Assumes the host model drives commands; this module drives the rest.
`timescale 1ns/1ps
module load_state_cmd_bench
  import load_state_pkg::*;
;
  logic              clk, rst_b, cmd_valid, rsp_valid, lim_wr;
  logic              limit_fail_flag;
  logic [8:0]        evt;
  logic [7:0]        rsp_data, error_status, trip_status, d;
  logic [MEAS_W-1:0] measured;
  cmd_t              cmd;
  limits_t           lim_new, lim_now;
  op_state_t         op_state;
  int                failures, samples_checked;
  wire logic [3:0]   ch1_err_pin;
  wire logic         oper_err_pin, over_power_trip, over_temp_trip;
  wire logic         over_voltage_trip, over_current_trip;
  logic [3:0]        ops [5] = '{OP_LOAD, OP_SHORT, OP_PRESET, OP_LEVEL,
                                 OP_DYNAMIC};
  logic              inv [5] = '{0, 1, 0, 0, 1};
  // Event pins packed so one word drives them all
  assign {ch1_err_pin, oper_err_pin, over_power_trip, over_temp_trip,
          over_voltage_trip, over_current_trip} = evt;
  load_state_cmd dut_u (.*);
  host_model host_u (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Released after one edge, or the command would repeat every cycle
  task set(input logic [3:0] op, input logic [1:0] a);
    host_u.send(1'b0, 1'b0, op, a);
    host_u.idle;
  endtask
  task q(input string n, input logic [3:0] op, input logic [7:0] e);
    host_u.ask(op, d);
    chk(n, d, e);
  endtask
  // Held three cycles so the two-flop synchroniser cannot miss it
  task pulse(input logic [8:0] v);
    @(negedge clk);
    evt = v;
    repeat (3) @(negedge clk);
    evt = 9'h000;
    repeat (4) @(negedge clk);
  endtask
  task lim(input logic [15:0] hi, lo);
    @(negedge clk);
    lim_new = {hi, lo};
    lim_wr = 1'b1;
    @(negedge clk);
    lim_wr = 1'b0;
  endtask
  task meas(input logic [15:0] v, input logic e);
    @(negedge clk);
    measured = v;
    repeat (2) @(negedge clk);
    chk("flag", limit_fail_flag, e);
    q("limfail", OP_LIMFAIL, {7'h0, e});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test;
  end
  initial begin
    rst_b = 1'b0;
    lim_wr = 1'b0;
    lim_new = 32'h0;
    measured = 16'h0;
    evt = 9'h000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    q("err_rst", OP_ERROR, 8'h00);
    q("trip_rst", OP_TRIP, 8'h00);
    chk("lim_rst", lim_now, 32'hffff0000);
    // Two-valued settings, some answered inverted
    foreach (ops[i])
      for (int a = 0; a < 2; a++) begin
        set(ops[i], 2'(a));
        q("twoval", ops[i], {7'h0, 1'(a) ^ inv[i]});
      end
    for (int m = 0; m < 4; m++) begin
      set(OP_MODE, 2'(m));
      q("mode", OP_MODE, 8'(m));
    end
    for (int s = 0; s < 3; s++) begin
      set(OP_SENSE, 2'(s));
      q("sense", OP_SENSE, {7'h0, s == 1});
    end
    set(OP_LOAD, 2'h1);
    host_u.send(1'b0, 1'b1, OP_LOAD, 2'h0);
    q("bad_keep", OP_LOAD, 8'h01);
    q("bad_err", OP_ERROR, 8'h20);
    set(OP_CLR, 2'h0);
    set(4'hf, 2'h0);
    q("unknown", OP_ERROR, 8'h20);
    set(OP_CLR, 2'h0);
    pulse(9'h008);
    q("trip_pwr", OP_TRIP, 8'h01);
    pulse(9'h0b7);
    q("trip_all", OP_TRIP, 8'h0f);
    q("err_bits", OP_ERROR, 8'h15);
    set(OP_CLR, 2'h0);
    q("clr_err", OP_ERROR, 8'h00);
    q("clr_trip", OP_TRIP, 8'h00);
    lim(16'd10, 16'd5);
    chk("lim_new", lim_now, {16'd10, 16'd5});
    meas(16'd7, 1'b0);
    meas(16'd11, 1'b1);
    meas(16'd4, 1'b1);
    meas(16'd10, 1'b0);
    meas(16'd5, 1'b0);
    lim(16'd3, 16'd9);
    chk("lim_keep", lim_now, {16'd10, 16'd5});
    repeat (2) @(negedge clk);
    q("lim_err", OP_ERROR, 8'h10);
    end_of_test;
  end
endmodule
